// File: rtl/rsh_pkg.sv
// Constants, register map and carrier types for the reference switchover block
package rsh_pkg;

  // Register byte offsets
  localparam logic [9:0] ADDR_DIV_A_LO  = 10'h010;
  localparam logic [9:0] ADDR_DIV_A_HI  = 10'h011;
  localparam logic [9:0] ADDR_DIV_B_LO  = 10'h012;
  localparam logic [9:0] ADDR_DIV_B_HI  = 10'h013;
  localparam logic [9:0] ADDR_RX_CFG    = 10'h01A;
  localparam logic [9:0] ADDR_LOOP_MISC = 10'h01C;
  localparam logic [9:0] ADDR_STATUS    = 10'h01F;
  localparam logic [9:0] ADDR_PWR_DOWN  = 10'h233;

  // Receiver configuration fields
  localparam int RX_OSC_CMOS = 0;
  localparam int RX_OSC_SEPD = 1;
  localparam int RX_A_SEPD   = 2;
  localparam int RX_B_SEPD   = 3;
  localparam int RX_A_CMOS   = 5;
  localparam int RX_B_CMOS   = 6;

  // Loop miscellaneous control fields
  localparam int MISC_AUTO    = 0;
  localparam int MISC_REVERT  = 1;
  localparam int MISC_MAN_SEL = 2;
  localparam int MISC_PIN_SEL = 3;
  localparam int MISC_CP_MID  = 6;
  localparam int MISC_INDEP   = 7;

  // Power-down control fields
  localparam int PD_LOOP = 2;

  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [9:0] RST_DIV  = 10'h001;

  // Timing
  localparam longint unsigned CLK_HZ        = 64'd200_000_000;
  localparam longint unsigned LOOP_BW_HZ    = 64'd10;
  localparam longint unsigned LOCK_TAU_MULT = 64'd10;
  localparam longint unsigned LOCK_WAIT_CYC = LOCK_TAU_MULT * CLK_HZ / LOOP_BW_HZ;
  localparam logic [31:0]     MON_TIMEOUT_CYC = 32'h0010_0000;

  typedef enum logic [2:0] {
    ST_PRIMARY   = 3'h1,
    ST_SECONDARY = 3'h2,
    ST_HOLDOVER  = 3'h4
  } rsh_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsh_bus_t;

  typedef struct packed {
    logic       osc_cmos;
    logic       osc_diff_pd;
    logic       osc_se_pd;
    logic [1:0] ref_cmos;
    logic [1:0] ref_diff_pd;
    logic [1:0] ref_se_pd;
  } rsh_rx_t;

  typedef struct packed {
    logic holdover;
    logic present_b;
    logic present_a;
    logic active_b;
  } rsh_status_t;

endpackage : rsh_pkg

// File: rtl/rsh_ref_switch.sv
// Reference prescale, presence monitor, switchover and holdover control
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1 - CMOS mode bits 5 and 6 per reference
// RULE2 - Differential receiver off unless selected, loop up
// RULE3 - Single-ended buffer off: loop down, own, differential
// RULE4 - Secondary divider shares primary unless bit 7
// RULE5 - Oscillator receiver set by low two bits
// RULE6 - Oscillator receiver off while loop power-down
// RULE7 - Software keeps loop up when bypassing it
// RULE8 - Prescale ratio anywhere from 1 to 1023
// RULE9 - Monitor judges presence after prescale dividers
// RULE10 - Manual selection by register or pin
// RULE11 - Auto: primary lost, secondary present, switch
// RULE12 - Nonrevertive: stay on secondary after return
// RULE13 - Nonrevertive: secondary lost, go to primary
// RULE14 - Revertive: back to primary once it returns
// RULE15 - Both absent: enter holdover on VCXO
// RULE16 - Holdover tristates charge pump by default
// RULE17 - Leave holdover when reference returns, resync
// RULE18 - Bit 6 forces pump to mid-supply
// RULE19 - Lock wait is ten loop time constants
// RULE20 - Single present reference becomes active
// RULE21 - Status shows active, presence and holdover
// RULE22 - Presence synchronised before selection logic
module rsh_ref_switch #(
  parameter logic [31:0] MON_TIMEOUT = rsh_pkg::MON_TIMEOUT_CYC,
  parameter logic [31:0] LOCK_WAIT   = 32'(rsh_pkg::LOCK_WAIT_CYC)
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // Register port
  input  wire rsh_pkg::rsh_bus_t i_bus,
  output logic [7:0]             o_rdata,
  // Reference clocks, index 0 primary
  input  wire logic [1:0]        i_ref,
  input  wire logic              i_ref_sel_pin,
  // Receiver controls
  output rsh_pkg::rsh_rx_t       o_rx,
  // Loop controls and status
  output rsh_pkg::rsh_status_t   o_status,
  output logic                   o_cp_tristate,
  output logic                   o_cp_midsupply,
  output logic                   o_resync,
  output logic                   o_lock_wait
);
  import rsh_pkg::*;

  logic [7:0]  rx_cfg;
  logic [7:0]  loop_misc;
  logic [7:0]  pwr_down;
  logic [9:0]  div_val [2];
  logic [1:0]  present;
  logic        loop_pd;
  logic        sel_s1;
  logic        sel_s2;
  logic        manual_sel;
  logic        changed;
  logic [31:0] lw_cnt;
  rsh_rx_t     next_rx;
  rsh_state_t  state;
  rsh_state_t  next_state;

  assign loop_pd = pwr_down[PD_LOOP];

  // Register writes
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_cfg     <= RST_REG8;
      loop_misc  <= RST_REG8;
      pwr_down   <= RST_REG8;
      div_val[0] <= RST_DIV;
      div_val[1] <= RST_DIV;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_RX_CFG:    rx_cfg    <= i_bus.wdata;
        ADDR_LOOP_MISC: loop_misc <= i_bus.wdata;
        ADDR_PWR_DOWN:  pwr_down  <= i_bus.wdata;
        ADDR_DIV_A_LO:  div_val[0][7:0] <= i_bus.wdata;
        ADDR_DIV_A_HI:  div_val[0][9:8] <= i_bus.wdata[1:0];
        ADDR_DIV_B_LO:  div_val[1][7:0] <= i_bus.wdata;
        ADDR_DIV_B_HI:  div_val[1][9:8] <= i_bus.wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= RST_REG8;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_RX_CFG:    o_rdata <= rx_cfg;
        ADDR_LOOP_MISC: o_rdata <= loop_misc;
        ADDR_PWR_DOWN:  o_rdata <= pwr_down;
        ADDR_DIV_A_LO:  o_rdata <= div_val[0][7:0];
        ADDR_DIV_A_HI:  o_rdata <= {6'h00, div_val[0][9:8]};
        ADDR_DIV_B_LO:  o_rdata <= div_val[1][7:0];
        ADDR_DIV_B_HI:  o_rdata <= {6'h00, div_val[1][9:8]};
        ADDR_STATUS:    o_rdata <= {4'h0, o_status};
        default:        o_rdata <= RST_REG8;
      endcase
    end else begin
      o_rdata <= RST_REG8;
    end
  end

  // Receiver mode and power-down
  always_comb begin
    next_rx             = '0;
    next_rx.ref_cmos    = {rx_cfg[RX_B_CMOS], rx_cfg[RX_A_CMOS]}; // RULE1
    next_rx.ref_diff_pd = {2{loop_pd}} | next_rx.ref_cmos; // RULE2
    next_rx.ref_se_pd   = {2{loop_pd}} // RULE3
                        | {rx_cfg[RX_B_SEPD], rx_cfg[RX_A_SEPD]}
                        | ~next_rx.ref_cmos;
    next_rx.osc_cmos    = rx_cfg[RX_OSC_CMOS]; // RULE5
    next_rx.osc_diff_pd = loop_pd | next_rx.osc_cmos; // RULE6
    next_rx.osc_se_pd   = loop_pd | rx_cfg[RX_OSC_SEPD] | ~next_rx.osc_cmos; // RULE6
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx <= '0;
    end else begin
      o_rx <= next_rx;
    end
  end

  // Per-reference prescaler and presence monitor
  genvar g;
  for (g = 0; g < 2; g++) begin : g_ref
    logic        s1;
    logic        s2;
    logic        s3;
    logic        rise;
    logic        div_pulse;
    logic [9:0]  div_sel;
    logic [9:0]  lim;
    logic [9:0]  cnt;
    logic [31:0] mon;

    // Reference is asynchronous to i_clk
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
      end else begin
        s1 <= i_ref[g]; // RULE22
        s2 <= s1;
        s3 <= s2;
      end
    end

    assign rise    = s2 & ~s3;
    assign div_sel = (g == 0 || !loop_misc[MISC_INDEP]) ? div_val[0] : div_val[g]; // RULE4
    // Zero is taken as divide by one
    assign lim     = (div_sel == 10'h000) ? 10'h000 : div_sel - 10'h001; // RULE8

    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        cnt       <= 10'h000;
        div_pulse <= 1'b0;
      end else begin
        div_pulse <= rise && (cnt >= lim);
        if (rise) begin
          cnt <= (cnt >= lim) ? 10'h000 : cnt + 10'h001; // RULE8
        end
      end
    end

    // Absent once no divided edge for MON_TIMEOUT cycles
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        mon <= MON_TIMEOUT;
      end else if (loop_pd) begin
        mon <= MON_TIMEOUT;
      end else if (div_pulse) begin
        mon <= 32'h0000_0000; // RULE9
      end else if (mon != MON_TIMEOUT) begin
        mon <= mon + 32'h0000_0001;
      end
    end

    assign present[g] = (mon != MON_TIMEOUT); // RULE9
  end

  // Select pin synchroniser
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
    end else begin
      sel_s1 <= i_ref_sel_pin;
      sel_s2 <= sel_s1;
    end
  end

  assign manual_sel = loop_misc[MISC_PIN_SEL] ? sel_s2 : loop_misc[MISC_MAN_SEL]; // RULE10

  // Switchover decision
  always_comb begin
    next_state = state;
    if (present == 2'b00) begin
      next_state = ST_HOLDOVER; // RULE15
    end else if (!loop_misc[MISC_AUTO]) begin
      next_state = manual_sel ? ST_SECONDARY : ST_PRIMARY; // RULE10
    end else if (present == 2'b01) begin
      next_state = ST_PRIMARY; // RULE13 RULE20
    end else if (present == 2'b10) begin
      next_state = ST_SECONDARY; // RULE11 RULE20
    end else begin
      case (state)
        ST_PRIMARY: begin
          next_state = ST_PRIMARY;
        end
        ST_SECONDARY: begin
          // RULE12 RULE14
          next_state = loop_misc[MISC_REVERT] ? ST_PRIMARY : ST_SECONDARY;
        end
        ST_HOLDOVER: begin
          next_state = ST_PRIMARY; // RULE17
        end
        default: begin
          next_state = ST_PRIMARY;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_HOLDOVER;
    end else begin
      state <= next_state;
    end
  end

  // Charge pump follows the state it enters
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cp_tristate  <= 1'b1;
      o_cp_midsupply <= 1'b0;
    end else begin
      o_cp_tristate  <= (next_state == ST_HOLDOVER) && !loop_misc[MISC_CP_MID]; // RULE16
      o_cp_midsupply <= (next_state == ST_HOLDOVER) && loop_misc[MISC_CP_MID]; // RULE18
    end
  end

  // Any move onto a reference restarts the loop
  assign changed = (next_state != state) && (next_state != ST_HOLDOVER);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_resync <= 1'b0;
    end else begin
      o_resync <= changed; // RULE17
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lw_cnt <= 32'h0000_0000;
    end else if (changed) begin
      lw_cnt <= LOCK_WAIT; // RULE19
    end else if (state == ST_HOLDOVER) begin
      lw_cnt <= 32'h0000_0000;
    end else if (lw_cnt != 32'h0000_0000) begin
      lw_cnt <= lw_cnt - 32'h0000_0001;
    end
  end

  assign o_lock_wait = (lw_cnt != 32'h0000_0000);

  // Status is registered to keep it glitch free
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status <= '0;
    end else begin
      o_status.active_b  <= (next_state == ST_SECONDARY); // RULE21
      o_status.present_a <= present[0];
      o_status.present_b <= present[1];
      o_status.holdover  <= (next_state == ST_HOLDOVER);
    end
  end

  // Checks
  a_ref_cmos_mode: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE1
    o_rx.ref_cmos == $past({rx_cfg[RX_B_CMOS], rx_cfg[RX_A_CMOS]}))
    else $error("reference cmos mode mismatch");

  a_diff_rx_off: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE2
    $past(loop_pd) |-> (&o_rx.ref_diff_pd))
    else $error("differential receiver alive with loop down");

  a_se_buf_off: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE3
    $past(loop_pd) |-> (&o_rx.ref_se_pd))
    else $error("single-ended buffer alive with loop down");

  a_osc_rx_off: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE6
    loop_pd ##1 loop_pd |-> o_rx.osc_diff_pd && o_rx.osc_se_pd)
    else $error("oscillator receiver alive with loop down");

  a_holdover_entry: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE15
    present == 2'b00 |=> state == ST_HOLDOVER && o_status.holdover)
    else $error("no holdover with both references absent");

  a_cp_holdover: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE16
    state == ST_HOLDOVER |-> (o_cp_tristate ^ o_cp_midsupply))
    else $error("charge pump not parked in holdover");

  a_cp_mid_only: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE18
    o_cp_midsupply |-> state == ST_HOLDOVER && $past(loop_misc[MISC_CP_MID]))
    else $error("mid-supply outside holdover");

  a_auto_failover: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE11
    loop_misc[MISC_AUTO] && present == 2'b10 |=> state == ST_SECONDARY)
    else $error("no switch to secondary");

  a_nonrevert_stay: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE12
    state == ST_SECONDARY && loop_misc[MISC_AUTO] && !loop_misc[MISC_REVERT]
    && present == 2'b11 |=> state == ST_SECONDARY)
    else $error("nonrevertive mode left secondary");

  a_revert_back: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE14
    state == ST_SECONDARY && loop_misc[MISC_AUTO] && loop_misc[MISC_REVERT]
    && present[0] |=> state == ST_PRIMARY)
    else $error("revertive mode stayed on secondary");

  a_manual_select: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE10
    !loop_misc[MISC_AUTO] && present != 2'b00 |=>
    state == ($past(manual_sel) ? ST_SECONDARY : ST_PRIMARY))
    else $error("manual selection ignored");

  a_resync_wait: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE19
    o_resync |-> o_lock_wait && lw_cnt == LOCK_WAIT)
    else $error("lock wait not started on resync");

endmodule : rsh_ref_switch

`default_nettype wire

// File: testbench/rsh_ref_model.sv
// Behavioural pair of redundant reference clocks
`timescale 1ns/10ps
`default_nettype none
module rsh_ref_model #(
  parameter int HALF_A = 31,
  parameter int HALF_B = 37
) (
  // Enables, index 0 primary
  input  wire logic [1:0] i_en,
  // Reference clocks
  output wire logic [1:0] o_ref
);
  logic ref_a;
  logic ref_b;
  // A lost source stops toggling; unrelated periods keep phases drifting
  initial begin
    ref_a = 1'b0;
    ref_b = 1'b0;
  end
  always begin
    #(HALF_A);
    if (i_en[0]) ref_a = ~ref_a;
  end
  always begin
    #(HALF_B);
    if (i_en[1]) ref_b = ~ref_b;
  end
  assign o_ref = {ref_b, ref_a};
endmodule : rsh_ref_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the reference switchover block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rsh_pkg::*;
  localparam logic [31:0] MT = 32'h0000_0190;
  localparam logic [31:0] LW = 32'h0000_0014;
  logic        i_clk, i_nrst, i_ref_sel_pin, o_cp_tristate, o_cp_midsupply, o_resync, o_lock_wait;
  rsh_bus_t    i_bus;
  rsh_rx_t     o_rx;
  rsh_status_t o_status;
  logic [7:0]  o_rdata, misc, pd, rv;
  logic [1:0]  i_ref, en;
  logic [31:0] rng;
  int          errors, cmp_count, nres, nexp, st, run;
  // Holdover exits enable one reference only; both at once races their first divided edges
  logic [9:0]  seq [10] = '{10'h301, 10'h101, 10'h201, 10'h001, 10'h101, 10'h203, 10'h043, 10'h143, 10'h203, 10'h303};

  rsh_ref_switch #(.MON_TIMEOUT(MT), .LOCK_WAIT(LW)) u_rsh_ref_switch (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_ref(i_ref), .i_ref_sel_pin(i_ref_sel_pin), .o_rx(o_rx),
    .o_status(o_status), .o_cp_tristate(o_cp_tristate), .o_cp_midsupply(o_cp_midsupply),
    .o_resync(o_resync), .o_lock_wait(o_lock_wait));
  rsh_ref_model u_rsh_ref_model (.i_en(en), .o_ref(i_ref));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Reference selection model; manual choice wins unless both are gone
  function automatic int nxt(input int s, input logic pa, input logic pb);
    if (!pa && !pb) return 2;
    if (!misc[MISC_AUTO]) return int'(misc[MISC_PIN_SEL] ? i_ref_sel_pin : misc[MISC_MAN_SEL]);
    if (pa && !pb) return 0;
    if (pb && !pa) return 1;
    if (s == 2 || misc[MISC_REVERT]) return 0;
    return s;
  endfunction : nxt

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_bus <= '0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus <= '0;
    #1 check({24'h0, o_rdata}, {24'h0, e}, "read data");
  endtask : rd

  task automatic step(input logic [1:0] e, input logic [7:0] m);
    int          ns;
    logic [1:0]  p;
    misc = m;
    wr(ADDR_LOOP_MISC, m);
    en <= e;
    repeat (600) @(posedge i_clk);
    p = e & {2{~pd[PD_LOOP]}};
    ns = nxt(st, p[0], p[1]);
    if (ns != st && ns != 2) nexp++;
    st = ns;
    #1;
    check(o_status[3:1], {ns == 2, p[1], p[0]}, "presence");
    if (ns != 2) check(o_status.active_b, ns == 1, "active");
    check({o_cp_tristate, o_cp_midsupply}, {ns == 2 && !m[6], ns == 2 && m[6]}, "pump");
    check(nres, nexp, "resync count");
  endtask : step

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Lock wait must run its full length after each resync
  always @(posedge i_clk) begin
    if (o_resync === 1'b1) nres++;
    if (o_lock_wait === 1'b1) begin
      run++;
    end else if (run != 0) begin
      check(run, LW, "lock wait");
      run = 0;
    end
  end

  initial begin
    repeat (30000) @(posedge i_clk);
    errors++;
    results();
  end

  initial begin
    i_nrst = 1'b0;
    i_bus = '0;
    i_ref_sel_pin = 1'b0;
    en = 2'b00;
    rng = 32'hac81;
    st = 2;
    pd = 8'h00;
    misc = 8'h00;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 check(o_rx, 9'h043, "rx reset");
    check({o_status, o_cp_tristate, o_cp_midsupply}, 6'h22, "status reset");
    rd(ADDR_DIV_A_LO, 8'h01);
    rd(10'h3FF, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h08);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      rv = rng[7:0] & 8'h6F;
      pd = (i == 7) ? 8'h00 : {5'h00, rng[9], 2'b00};
      wr(ADDR_RX_CFG, rv);
      wr(ADDR_PWR_DOWN, pd);
      repeat (2) @(posedge i_clk);
      #1 check(o_rx, {rv[0], rv[0] | pd[2], pd[2] | rv[1] | ~rv[0], rv[6:5],
        rv[6] | pd[2], rv[5] | pd[2], pd[2] | rv[3] | ~rv[6], pd[2] | rv[2] | ~rv[5]}, "rx");
      rd(ADDR_RX_CFG, rv);
      rd(ADDR_PWR_DOWN, pd);
    end
    $display("test receivers done");
    wr(ADDR_DIV_A_LO, 8'hFF);
    wr(ADDR_DIV_A_HI, 8'hFF);
    rd(ADDR_DIV_A_HI, 8'h03);
    wr(ADDR_LOOP_MISC, 8'h01);
    en <= 2'b10;
    repeat (1500) @(posedge i_clk);
    #1 check(o_status.present_b, 1'b0, "shared divider");
    step(2'b10, 8'h81);
    wr(ADDR_DIV_A_LO, 8'h01);
    wr(ADDR_DIV_A_HI, 8'h00);
    $display("test dividers done");
    foreach (seq[i]) step(seq[i][9:8], seq[i][7:0]);
    $display("test automatic done");
    step(2'b11, 8'h04);
    step(2'b11, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      @(posedge i_clk);
      i_ref_sel_pin <= rng[3];
      step(2'b11, 8'h08);
    end
    $display("test manual done");
    results();
  end
endmodule : testbench
`default_nettype wire
